/* File: src/fscg_pkg.sv */
// Package for the flash security command gate: offsets, fields, codes.
package fscg_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] FSCG_OFF_FLAGS = 8'h00;
  localparam logic [7:0] FSCG_OFF_BOOT_END = 8'h04;
  localparam logic [7:0] FSCG_OFF_REQ = 8'h08;
  localparam logic [7:0] FSCG_OFF_STATUS = 8'h0C;
  // Security flag positions
  localparam int FSCG_BIT_CHIP_LOCK = 0;
  localparam int FSCG_BIT_BLOCK_LOCK = 1;
  localparam int FSCG_BIT_PROG_LOCK = 2;
  localparam int FSCG_BIT_BOOT_PROT = 3;
  // Widths
  localparam int FSCG_BLK_W = 8;
  // Reset values
  localparam logic [3:0] FSCG_FLAGS_RST = 4'h0;
  localparam logic [7:0] FSCG_BOOT_END_RST = 8'h00;
  // Request fields in the request register
  localparam int FSCG_REQ_START_LSB = 8;
  localparam int FSCG_REQ_END_LSB = 16;
  // Command codes
  typedef enum logic [1:0] {
    FSCG_CMD_NONE = 2'b00,
    FSCG_CMD_CHIP_ERASE = 2'b01,
    FSCG_CMD_BLOCK_ERASE = 2'b10,
    FSCG_CMD_PROGRAM = 2'b11
  } fscg_cmd_t;
  // Result codes
  localparam logic [1:0] FSCG_RES_IDLE = 2'h0;
  localparam logic [1:0] FSCG_RES_OK = 2'h1;
  localparam logic [1:0] FSCG_RES_ERR = 2'h2;
endpackage

/* File: src/fscg_decide.sv */
// Combinational accept/reject decision for one flash command.
`timescale 1ns/1ps
`default_nettype none
module fscg_decide
  import fscg_pkg::*;
(
  // Command
  input wire fscg_cmd_t cmd,
  input wire logic [FSCG_BLK_W-1:0] blk_start,
  input wire logic [FSCG_BLK_W-1:0] blk_end,
  // Security state
  input wire logic [3:0] flags,
  input wire logic [FSCG_BLK_W-1:0] boot_end,
  // Verdict
  output logic accept
);
  // Range touches boot area when its low end is at or below the boot end
  wire hits_boot = (blk_start <= boot_end);
  wire chip_lock = flags[FSCG_BIT_CHIP_LOCK];
  wire block_lock = flags[FSCG_BIT_BLOCK_LOCK];
  wire prog_lock = flags[FSCG_BIT_PROG_LOCK];
  wire boot_prot = flags[FSCG_BIT_BOOT_PROT];
  wire range_ok = (blk_start <= blk_end);
  // Chip erase: only chip lock and boot protect stop it
  wire ok_chip = !chip_lock && !boot_prot;
  // Block erase: any of the first three locks stops it, boot area is shielded
  wire ok_blk = !chip_lock && !block_lock && !prog_lock && range_ok
                && !(boot_prot && hits_boot);
  // Program: stays open under chip lock, since nothing can be erased anyway
  wire ok_prog = !prog_lock && range_ok && !(boot_prot && hits_boot);
  // Select verdict by command
  assign accept = (cmd == FSCG_CMD_CHIP_ERASE) ? ok_chip :
                  (cmd == FSCG_CMD_BLOCK_ERASE) ? ok_blk :
                  (cmd == FSCG_CMD_PROGRAM) ? ok_prog : 1'b0;
endmodule // fscg_decide
`default_nettype wire

/* File: src/fscg_top.sv */
// Flash security command gate with a classic Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
module fscg_top
  import fscg_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Flash operation strobe toward the flash sequencer
  output logic FLASH_GO,
  output fscg_cmd_t FLASH_CMD,
  output logic [FSCG_BLK_W-1:0] FLASH_BLK_START,
  output logic [FSCG_BLK_W-1:0] FLASH_BLK_END,
  // Result of last request
  output logic REQ_ERROR
);
  import fscg_pkg::*;

  // Registers
  logic [3:0] flags_reg; // Security flags, set-only except chip erase
  wire [3:0] flags_next; // Built bit by bit in the flag cells below
  logic [FSCG_BLK_W-1:0] boot_end_reg, boot_end_next; // Boot cluster end block
  fscg_cmd_t cmd_reg, cmd_next; // Last command
  logic [FSCG_BLK_W-1:0] start_reg, start_next; // Last range start
  logic [FSCG_BLK_W-1:0] end_reg, end_next; // Last range end
  logic [1:0] res_reg, res_next; // Last result
  logic go_reg, go_next; // One-cycle flash strobe
  logic err_reg, err_next; // Last command was refused, drives the error pin
  logic ack_reg; // Bus acknowledge
  logic [31:0] rdat_reg; // Read data

  // Address match; one helper for the write strobes and the read mux
  function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] off);
    adr_hit = (adr == off);
  endfunction

  // Bus decode
  // A request is taken once; the strobe still held in the ack cycle is ignored
  wire bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  wire wr_req = bus_req && WB_WE_I;
  wire sel_flags = adr_hit(WB_ADR_I, FSCG_OFF_FLAGS);
  wire sel_boot = adr_hit(WB_ADR_I, FSCG_OFF_BOOT_END);
  wire sel_req = adr_hit(WB_ADR_I, FSCG_OFF_REQ);
  wire sel_stat = adr_hit(WB_ADR_I, FSCG_OFF_STATUS);
  wire wr_flags = wr_req && sel_flags && WB_SEL_I[0];
  wire wr_boot = wr_req && sel_boot && WB_SEL_I[0];
  wire wr_cmd = wr_req && sel_req && (&WB_SEL_I[2:0]);

  // Request fields as written
  // Command in the low bits, start block above it, end block above that
  wire fscg_cmd_t req_cmd = fscg_cmd_t'(WB_DAT_I[1:0]);
  wire [FSCG_BLK_W-1:0] req_start = WB_DAT_I[FSCG_REQ_START_LSB +: FSCG_BLK_W];
  wire [FSCG_BLK_W-1:0] req_end = WB_DAT_I[FSCG_REQ_END_LSB +: FSCG_BLK_W];

  // Verdict from the decision module
  // It sees the flags as they stood before this edge
  logic accept;
  fscg_decide u_decide (
    .cmd(req_cmd),
    .blk_start(req_start),
    .blk_end(req_end),
    .flags(flags_reg),
    .boot_end(boot_end_reg),
    .accept(accept)
  );

  // A command write with the none code is ignored, neither accepted nor refused
  wire go_ok = wr_cmd && (req_cmd != FSCG_CMD_NONE) && accept;
  // Refused: the decision module saw a lock, a boot area hit or a start above the end
  wire go_bad = wr_cmd && (req_cmd != FSCG_CMD_NONE) && !accept;
  // Only an accepted chip erase may clear locks, never a refused one
  wire chip_erased = go_ok && (req_cmd == FSCG_CMD_CHIP_ERASE);

  // Flags: software can only set; chip erase clears block and program locks
  // Chip lock and boot protect have no clearing path, so they hold until reset
  wire [3:0] flags_set = wr_flags ? WB_DAT_I[3:0] : 4'h0;
  wire [3:0] flags_clr;
  // One cell per flag; a set in the same cycle as a clear wins
  genvar fi;
  generate
    for (fi = 0; fi < 4; fi = fi + 1) begin : g_flag
      // Only block and program locks have a clearing path
      localparam bit clearable = (fi == FSCG_BIT_BLOCK_LOCK) || (fi == FSCG_BIT_PROG_LOCK);
      assign flags_clr[fi] = clearable && chip_erased;
      assign flags_next[fi] = flags_set[fi] || (flags_reg[fi] && !flags_clr[fi]);
    end
  endgenerate

  // Boot end frozen once boot protect is on, so the area cannot shrink
  // Before protect is set the boundary may be moved freely
  assign boot_end_next = (wr_boot && !flags_reg[FSCG_BIT_BOOT_PROT]) ?
                         WB_DAT_I[FSCG_BLK_W-1:0] : boot_end_reg;

  // Rejected requests raise no strobe and leave the flash alone
  assign go_next = go_ok;
  assign cmd_next = go_ok ? req_cmd : cmd_reg;
  assign start_next = go_ok ? req_start : start_reg;
  assign end_next = go_ok ? req_end : end_reg;
  assign res_next = go_ok ? FSCG_RES_OK : (go_bad ? FSCG_RES_ERR : res_reg);

  // Read mux; unmapped addresses read zero
  // Request reads back the last accepted command, not the last one written
  wire [31:0] rd_mux = sel_flags ? {28'h000_0000, flags_reg} :
                       sel_boot ? {24'h00_0000, boot_end_reg} :
                       sel_req ? {8'h00, end_reg, start_reg, 6'h00, cmd_reg} :
                       sel_stat ? {30'h0000_0000, res_reg} : 32'h0000_0000;

  // Error level follows only command writes; reads and flag writes keep it
  assign err_next = go_ok ? 1'b0 : (go_bad ? 1'b1 : err_reg);

  // Security flags
  // Reset stands in for a fresh part: the flags are not kept across it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_reg <= FSCG_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Boot cluster end block
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      boot_end_reg <= FSCG_BOOT_END_RST;
    end else begin
      boot_end_reg <= boot_end_next;
    end
  end

  // Command of the last accepted request
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cmd_reg <= FSCG_CMD_NONE;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // Block range of the last accepted request
  // Held after the strobe so the sequencer may read it at its own pace
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      start_reg <= 8'h00;
      end_reg <= 8'h00;
    end else begin
      start_reg <= start_next;
      end_reg <= end_next;
    end
  end

  // Status word and error level of the last request
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      res_reg <= FSCG_RES_IDLE;
      err_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      err_reg <= err_next;
    end
  end

  // Start strobe, high for one cycle, in the same cycle as the ack
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= go_next;
    end
  end

  // Bus answer: ack one cycle after the request, dropped next cycle
  // Gating the request with ack_reg keeps a held strobe from a second ack
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read data captured with the ack and held until the next access
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdat_reg <= 32'h0000_0000;
    end else if (bus_req) begin
      rdat_reg <= rd_mux;
    end
  end

  // Outputs straight from flops
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;
  assign FLASH_GO = go_reg;
  assign FLASH_CMD = cmd_reg;
  assign FLASH_BLK_START = start_reg;
  assign FLASH_BLK_END = end_reg;
  assign REQ_ERROR = err_reg;
endmodule // fscg_top
`default_nettype wire

/* File: test/fscg_top_props.sv */
// Port checker for the flash security command gate.
`timescale 1ns/1ps
`default_nettype none
module fscg_top_props
  import fscg_pkg::*;
(
  // Clock, reset, bus
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic WB_ACK_O,
  // Flash side
  input wire logic FLASH_GO,
  input wire fscg_cmd_t FLASH_CMD,
  input wire logic [FSCG_BLK_W-1:0] FLASH_BLK_START,
  input wire logic [FSCG_BLK_W-1:0] FLASH_BLK_END,
  input wire logic REQ_ERROR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Request taken when strobed and not yet answered
  wire logic req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  chk_ack_next: assert property (req |=> WB_ACK_O) else $error("ack late");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  chk_go_ack: assert property (FLASH_GO |-> WB_ACK_O) else $error("go without ack");
  chk_go_noerr: assert property (FLASH_GO |-> !REQ_ERROR) else $error("go with error");
  chk_go_write: assert property (FLASH_GO |-> $past(WB_WE_I)) else $error("go on read");
  chk_cmd_hold: assert property (!FLASH_GO |-> $stable(FLASH_CMD)) else $error("cmd moved");
  chk_range_order: assert property (FLASH_GO && FLASH_CMD != FSCG_CMD_CHIP_ERASE |->
    FLASH_BLK_START <= FLASH_BLK_END) else $error("bad range");
  chk_err_hold: assert property (!WB_ACK_O |-> $stable(REQ_ERROR)) else $error("error moved");
  // Main scenarios reached
  cover property (FLASH_GO && FLASH_CMD == FSCG_CMD_CHIP_ERASE);
  cover property (WB_ACK_O && REQ_ERROR);
  cover property (FLASH_GO ##[2:20] FLASH_GO);
endmodule // fscg_top_props
bind fscg_top fscg_top_props u_props (.CLK_SYS, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ACK_O,
  .FLASH_GO, .FLASH_CMD, .FLASH_BLK_START, .FLASH_BLK_END, .REQ_ERROR);
`default_nettype wire

/* File: test/fscg_flash_model.sv */
// Flash sequencer stand-in that counts started operations.
`timescale 1ns/1ps
`default_nettype none
module fscg_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start strobe and count
  input wire logic go,
  output logic [7:0] go_cnt
);
  // Each start touches the flash once; a rejected one must not
  always_ff @(posedge clk) begin
    if (rst) go_cnt <= 8'h00;
    else if (go) go_cnt <= go_cnt + 8'h01;
  end
endmodule // fscg_flash_model
`default_nettype wire

/* File: test/fscg_top_test.sv */
// Self-checking bench for the flash security command gate.
`timescale 1ns/1ps
`default_nettype none
module fscg_top_test;
  import fscg_pkg::*;
  // Bench signals
  logic clk = 0, rst = 1, cyc = 0, we = 0, go, ack, err;
  logic [7:0] adr = 8'h00, bs, be, gcnt;
  logic [31:0] di = 32'h0000_0000, dq, rd;
  fscg_cmd_t cmd;
  logic [17:0] xreq = 18'h0_0000; // Last accepted command and range
  int error_cnt = 0, tests_run = 0, exp_go = 0;
  fscg_top uut (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(di), .WB_DAT_O(dq), .WB_ACK_O(ack), .FLASH_GO(go), .FLASH_CMD(cmd),
    .FLASH_BLK_START(bs), .FLASH_BLK_END(be), .REQ_ERROR(err));
  fscg_flash_model fm (.clk(clk), .rst(rst), .go(go), .go_cnt(gcnt));
  initial forever #5 clk = ~clk;
  // Compare and count
  task automatic cmp(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // Counts, verdict, end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One classic Wishbone cycle; start strobe taken at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic g);
    int n;
    n = 0;
    cyc <= 1;
    we <= w;
    adr <= a;
    di <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    // Bound used up without an answer: count it and close the run
    if (ack !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    g = go;
    rd = dq;
    cyc <= 0;
    we <= 0;
    @(posedge clk);
  endtask
  // Issue one command; check strobe, error level, status, flash count
  task automatic op(input logic [1:0] c, input logic [7:0] s, input logic [7:0] e, input logic ok);
    logic g;
    // Chip mode always names the whole flash as its range
    if (c == 2'h1) begin
      s = 8'h00;
      e = 8'hFF;
    end
    bus(1, FSCG_OFF_REQ, {8'h00, e, s, 6'h00, c}, g);
    exp_go += ok;
    if (ok) xreq = {c, s, e};
    cmp(g, ok);
    cmp(err, !ok);
    cmp(gcnt, exp_go);
    cmp({cmd, bs, be}, xreq);
    bus(0, FSCG_OFF_STATUS, 32'h0000_0000, g);
    cmp(rd, ok ? FSCG_RES_OK : FSCG_RES_ERR);
  endtask
  // Read one register and compare it with the expected word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    logic g;
    bus(0, a, 32'h0000_0000, g);
    cmp(rd, x);
  endtask
  // Reset for four cycles, then load boot end and flags
  task automatic restart(input logic [3:0] f, input logic [7:0] b);
    logic g;
    rst <= 1;
    exp_go = 0;
    xreq = 18'h0_0000;
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(1, FSCG_OFF_BOOT_END, b, g);
    bus(1, FSCG_OFF_FLAGS, f, g);
  endtask
  // Scenario sequence: open part first, then one per flag
  initial begin
    logic g;
    restart(4'h0, 8'h00);
    op(2, 5, 6, 1);
    op(3, 6, 5, 0);
    $display("open part test done");
    restart(4'h1, 8'h00);
    op(1, 0, 0, 0);
    op(2, 5, 6, 0);
    op(3, 5, 6, 1);
    // Readback after program stands in for the checksum query
    rdchk(FSCG_OFF_REQ, {8'h00, 8'h06, 8'h05, 6'h00, 2'h3});
    bus(1, FSCG_OFF_FLAGS, 32'h0000_0000, g);
    rdchk(FSCG_OFF_FLAGS, 32'h0000_0001);
    op(1, 0, 0, 0);
    rdchk(8'h10, 32'h0000_0000);
    $display("chip lock test done");
    restart(4'h2, 8'h00);
    op(2, 5, 6, 0);
    op(3, 5, 6, 1);
    op(1, 0, 0, 1);
    rdchk(FSCG_OFF_FLAGS, 32'h0000_0000);
    op(2, 5, 6, 1);
    $display("block lock test done");
    restart(4'h4, 8'h00);
    op(3, 5, 6, 0);
    op(2, 5, 6, 0);
    op(1, 0, 0, 1);
    op(3, 5, 6, 1);
    // Auto-security: chosen flags written right after the program step
    bus(1, FSCG_OFF_FLAGS, 32'h0000_0004, g);
    op(3, 5, 6, 0);
    $display("program lock test done");
    restart(4'h8, 8'h04);
    op(1, 0, 0, 0);
    op(2, 4, 6, 0);
    op(2, 5, 6, 1);
    op(3, 5, 6, 1);
    bus(1, FSCG_OFF_BOOT_END, 32'h0000_0000, g);
    rdchk(FSCG_OFF_BOOT_END, 32'h0000_0004);
    op(3, 2, 3, 0);
    $display("boot protect test done");
    summarize();
  end
endmodule // fscg_top_test
`default_nettype wire
